// file: octal_psram_pkg.sv
// Purpose: Shared constants and types for the octal DDR pseudo-static memory device.
// Assumes: Link clock is driven by the host; the core clock runs at 125 MHz.
// Notes: Register layouts cover only the fields that the device logic uses.
package octal_psram_pkg;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int INIT_TIME_US = 150;
    localparam int CORE_CLK_MHZ = 125;
    localparam int INIT_CYCLES = INIT_TIME_US * CORE_CLK_MHZ;

    // ************************************************************
    // Opcodes and frame layout
    // ************************************************************
    localparam logic [7:0] OP_SYNC_RD = 8'h00;
    localparam logic [7:0] OP_SYNC_WR = 8'h80;
    localparam logic [7:0] OP_LIN_RD = 8'h20;
    localparam logic [7:0] OP_LIN_WR = 8'hA0;
    localparam logic [7:0] OP_REG_RD = 8'h40;
    localparam logic [7:0] OP_REG_WR = 8'hC0;
    localparam logic [7:0] OP_GLOBAL_RST = 8'hFF;
    localparam logic [5:0] CYC_A3 = 6'h01;
    localparam logic [5:0] CYC_A1 = 6'h02;
    localparam logic [5:0] CYC_A0 = 6'h03;
    localparam logic [5:0] CYC_MAX = 6'h3F;
    localparam logic [4:0] LAT_BASE = 5'h03;
    localparam logic [4:0] REG_WR_LAT = 5'h01;
    localparam int PAGE_LOG2 = 11;

    // ************************************************************
    // Configuration registers
    // ************************************************************
    localparam logic [7:0] REG_LATENCY_ADDR = 8'h00;
    localparam logic [7:0] REG_VENDOR_ADDR = 8'h01;
    localparam logic [7:0] REG_DEVICE_ADDR = 8'h02;
    localparam logic [7:0] REG_CAPAB_ADDR = 8'h03;
    localparam logic [7:0] REG_WRITE_ADDR = 8'h04;
    localparam logic [7:0] REG_BURST_ADDR = 8'h08;
    localparam logic [7:0] LATENCY_RST = 8'h08;
    localparam logic [7:0] WRITE_RST = 8'h40;
    localparam logic [7:0] BURST_RST = 8'h05;
    localparam logic [7:0] CAPAB_VAL = 8'h80;
    localparam int LT_BIT = 5;
    localparam int RLC_LSB = 2;
    localparam int WLC_LSB = 5;
    localparam int X16_BIT = 6;
    localparam int ROW_CROSS_BIT = 3;
    localparam int HYBRID_BIT = 2;
    localparam int BL_LSB = 0;

    typedef struct packed {
        logic [7:0] latency_cfg_reg;
        logic [7:0] write_cfg_reg;
        logic [7:0] burst_config_reg;
    } cfg_s;

    typedef enum {ST_CMD, ST_ADDR, ST_WAIT, ST_DATA, ST_IDLE} frame_e;

endpackage

// file: octal_psram_device.sv
// Purpose: Device side of an octal DDR pseudo-static memory link with a small array.
// Assumes: link_clk comes from the host and may stop outside frames.
// Notes: DDR outputs are muxed by link_clk between rise-half and fall-half flops, both loaded on the rising edge.
`timescale 1ns/1ps

// Notes on behaviour
// - Write mask high blocks that byte lane.
// - Lane 0 strobes all reads, lane 1 memory reads in x16 only.
// - Select high keeps device idle, bus ignored.
// - Reset pin active low, optional, weakly pulled.
// - Commands ignored until 150 us init ends.
// - Reset pin low restores configuration defaults.
// - Global reset frame restores configuration defaults.
// - Default hybrid wrap 32, configurable wrap lengths.
// - Opcode first rise, address on both edges of cycles two and three.
// - Column bit 10 ignored in sixteen-bit mode.
// - Linear opcodes ignore wrap settings entirely.
// - Row crossing only for enabled linear reads.
// - Read strobe driven low from third rise.
// - Read latency count, refresh pushes to double.
// - First strobe rise marks first read data.
// - Upper lane unused until latency in x16.
// - In x16 each mask lane gates own byte.
// - Register writes latency one, reads normal.
// - Registers eight bits on lower lane only.
module octal_psram_device #(
    parameter int INIT_CYCLES = octal_psram_pkg::INIT_CYCLES,
    parameter int MEM_AW = 16,
    parameter logic [7:0] VENDOR_VAL = 8'h00,
    parameter logic [7:0] DEVICE_VAL = 8'h00
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic hw_reset_n,
    input wire logic refresh_req,
    output logic init_done,
    output logic x16_mode,
    input wire logic link_clk,
    input wire logic ce_n,
    input wire logic [15:0] dq_i,
    output logic [15:0] dq_o,
    output logic [1:0] dq_oe,
    input wire logic [1:0] strobe_mask_line_i,
    output logic [1:0] strobe_mask_line_o,
    output logic [1:0] strobe_mask_line_oe
);

    // ************************
    // Core domain: reset pin and power-up timer
    // ************************
    localparam int PAGE_LOG2 = octal_psram_pkg::PAGE_LOG2;
    localparam int CNT_W = $clog2(INIT_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(INIT_CYCLES - 1);

    logic rst_s1_r;
    logic rst_s2_r;
    logic pin_rst_r;
    logic [CNT_W-1:0] init_cnt_r;
    logic x16_s1_r;
    logic cfg_rst;
    octal_psram_pkg::cfg_s cfg_r;

    // The pin is asynchronous, so it is synchronised before it may reset anything.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
            pin_rst_r <= 1'b1;
        end else begin
            rst_s1_r <= hw_reset_n;
            rst_s2_r <= rst_s1_r;
            pin_rst_r <= ~rst_s2_r;
        end
    end

    // Self-initialisation runs once after reset.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            init_cnt_r <= '0;
            init_done <= 1'b0;
        end else if (!init_done) begin
            init_cnt_r <= init_cnt_r + CNT_W'(1);
            init_done <= (init_cnt_r == CNT_LAST);
        end
    end

    // Width mode crosses back to the core as a level.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            x16_s1_r <= 1'b0;
            x16_mode <= 1'b0;
        end else begin
            x16_s1_r <= cfg_r.burst_config_reg[octal_psram_pkg::X16_BIT];
            x16_mode <= x16_s1_r;
        end
    end

    assign cfg_rst = rst | pin_rst_r;

    // ************************
    // Link domain: crossings and decode
    // ************************
    logic ini_s1_r;
    logic ini_s2_r;
    logic ref_s1_r;
    logic ref_s2_r;

    // Both levels cross with two flops; they are read only at the third rise.
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            ini_s1_r <= 1'b0;
            ini_s2_r <= 1'b0;
            ref_s1_r <= 1'b0;
            ref_s2_r <= 1'b0;
        end else begin
            ini_s1_r <= init_done;
            ini_s2_r <= ini_s1_r;
            ref_s1_r <= refresh_req;
            ref_s2_r <= ref_s1_r;
        end
    end

    octal_psram_pkg::frame_e st_r;
    logic [5:0] cyc_r;
    logic [7:0] op_r;
    logic [7:0] a3_r;
    logic [7:0] a2_r;
    logic [7:0] a1_r;
    logic [7:0] fall_r;
    logic [7:0] reg_addr_r;
    logic [15:0] rise_r;
    logic [1:0] rise_m_r;
    logic [MEM_AW-1:0] addr_r;
    logic [MEM_AW-1:0] hyb_base_r;
    logic [MEM_AW-1:0] cnt_r;
    logic hyb_done_r;
    logic wr_act_r;
    logic rwr_r;
    logic rd_data_r;
    logic push_r;
    logic gr_r;
    logic [15:0] out_rise_r;
    logic [15:0] out_fall_r;
    logic [7:0] mem [2**MEM_AW];

    logic x16;
    logic is_mem_rd;
    logic is_mem_wr;
    logic is_linear;
    logic is_rd;
    logic op_known;
    logic [4:0] rlat;
    logic [4:0] wlat;
    logic [4:0] lat;
    logic data_go;
    logic data_now;
    logic first;
    logic [7:0] reg_addr;
    logic [13:0] row_addr;
    logic [10:0] col_addr;
    logic [24:0] pin_addr;
    logic [MEM_AW-1:0] start;
    logic [MEM_AW-1:0] step;
    logic [MEM_AW-1:0] wl;
    logic [MEM_AW-1:0] nxt_lin;
    logic [MEM_AW-1:0] nxt_page;
    logic [MEM_AW-1:0] nxt_wrap;
    logic [MEM_AW-1:0] nxt;
    logic [MEM_AW-1:0] ra;

    // Returns the readable value of a configuration register.
    function automatic logic [7:0] reg_val(input logic [7:0] a, input octal_psram_pkg::cfg_s c);
        case (a)
            octal_psram_pkg::REG_LATENCY_ADDR: reg_val = c.latency_cfg_reg;
            octal_psram_pkg::REG_VENDOR_ADDR: reg_val = VENDOR_VAL; // Arbitrary value.
            octal_psram_pkg::REG_DEVICE_ADDR: reg_val = DEVICE_VAL; // Arbitrary value.
            octal_psram_pkg::REG_CAPAB_ADDR: reg_val = octal_psram_pkg::CAPAB_VAL;
            octal_psram_pkg::REG_WRITE_ADDR: reg_val = c.write_cfg_reg;
            octal_psram_pkg::REG_BURST_ADDR: reg_val = c.burst_config_reg;
            default: reg_val = 8'h00;
        endcase
    endfunction

    // Opcode class, latency choice and the start address.
    always_comb begin
        x16 = cfg_r.burst_config_reg[octal_psram_pkg::X16_BIT];
        is_mem_rd = (op_r == octal_psram_pkg::OP_SYNC_RD) || (op_r == octal_psram_pkg::OP_LIN_RD);
        is_mem_wr = (op_r == octal_psram_pkg::OP_SYNC_WR) || (op_r == octal_psram_pkg::OP_LIN_WR);
        is_linear = (op_r == octal_psram_pkg::OP_LIN_RD) || (op_r == octal_psram_pkg::OP_LIN_WR);
        is_rd = is_mem_rd || (op_r == octal_psram_pkg::OP_REG_RD);
        op_known = is_rd || is_mem_wr || (op_r == octal_psram_pkg::OP_REG_WR);
        rlat = {2'b00, cfg_r.latency_cfg_reg[octal_psram_pkg::RLC_LSB +: 3]}
            + octal_psram_pkg::LAT_BASE;
        wlat = {2'b00, cfg_r.write_cfg_reg[octal_psram_pkg::WLC_LSB],
            cfg_r.write_cfg_reg[octal_psram_pkg::WLC_LSB + 1],
            cfg_r.write_cfg_reg[octal_psram_pkg::WLC_LSB + 2]} + octal_psram_pkg::LAT_BASE;
        if (is_mem_rd && (push_r || cfg_r.latency_cfg_reg[octal_psram_pkg::LT_BIT])) begin
            lat = {rlat[3:0], 1'b0};
        end else if (is_rd) begin
            lat = rlat;
        end else if (is_mem_wr) begin
            lat = wlat;
        end else begin
            lat = octal_psram_pkg::REG_WR_LAT;
        end
        data_go = cyc_r >= ({1'b0, lat} + 6'h02);
        first = (st_r != octal_psram_pkg::ST_DATA);
        data_now = (st_r == octal_psram_pkg::ST_DATA) || (data_go && ((st_r ==
            octal_psram_pkg::ST_WAIT) || (st_r == octal_psram_pkg::ST_ADDR && cyc_r ==
            octal_psram_pkg::CYC_A0)));
        reg_addr = (cyc_r == octal_psram_pkg::CYC_A0) ? fall_r : reg_addr_r;
        row_addr = {a3_r[0], a2_r, a1_r[7:3]};
        col_addr = {a1_r[2:0], fall_r};
        pin_addr = x16 ? {row_addr, col_addr[9:0], 1'b0} : {row_addr, col_addr};
        start = pin_addr[MEM_AW-1:0];
    end

    // Next burst address: wrap, hybrid wrap, or linear inside or across a row.
    always_comb begin
        step = x16 ? MEM_AW'(4) : MEM_AW'(2);
        case (cfg_r.burst_config_reg[octal_psram_pkg::BL_LSB +: 2])
            2'b00: wl = MEM_AW'(16);
            2'b01: wl = MEM_AW'(32);
            2'b10: wl = MEM_AW'(64);
            default: wl = MEM_AW'(2048);
        endcase
        if (x16 && wl != MEM_AW'(2048)) begin
            wl = {wl[MEM_AW-2:0], 1'b0};
        end
        nxt_lin = addr_r + step;
        nxt_page = {addr_r[MEM_AW-1:PAGE_LOG2], nxt_lin[PAGE_LOG2-1:0]};
        nxt_wrap = (addr_r & ~(wl - MEM_AW'(1))) | (nxt_lin & (wl - MEM_AW'(1)));
        if (is_linear) begin
            nxt = (is_mem_rd && cfg_r.burst_config_reg[octal_psram_pkg::ROW_CROSS_BIT]) ?
                nxt_lin : nxt_page;
        end else if (hyb_done_r) begin
            nxt = nxt_page;
        end else if (cfg_r.burst_config_reg[octal_psram_pkg::HYBRID_BIT]
            && (cnt_r + step >= wl)) begin
            nxt = hyb_base_r;
        end else begin
            nxt = nxt_wrap;
        end
        ra = first ? addr_r : nxt;
    end

    // ************************
    // Link domain: frame sequencing on rising edges
    // ************************
    // Select high aborts the frame at once, whether or not the clock runs.
    always_ff @(posedge link_clk or posedge ce_n) begin
        if (ce_n) begin
            st_r <= octal_psram_pkg::ST_CMD;
            cyc_r <= 6'h00;
            op_r <= 8'h00;
            a3_r <= 8'h00;
            a2_r <= 8'h00;
            a1_r <= 8'h00;
            reg_addr_r <= 8'h00;
        end else begin
            if (cyc_r != octal_psram_pkg::CYC_MAX) begin
                cyc_r <= cyc_r + 6'h01;
            end
            case (st_r)
                octal_psram_pkg::ST_CMD: begin
                    op_r <= dq_i[7:0];
                    st_r <= octal_psram_pkg::ST_ADDR;
                end
                octal_psram_pkg::ST_ADDR: begin
                    if (cyc_r == octal_psram_pkg::CYC_A3) begin
                        a3_r <= dq_i[7:0];
                    end
                    if (cyc_r == octal_psram_pkg::CYC_A1) begin
                        a2_r <= fall_r;
                        a1_r <= dq_i[7:0];
                        if (!ini_s2_r || !op_known) begin
                            st_r <= octal_psram_pkg::ST_IDLE;
                        end
                    end
                    if (cyc_r == octal_psram_pkg::CYC_A0) begin
                        reg_addr_r <= fall_r;
                        st_r <= data_go ? octal_psram_pkg::ST_DATA : octal_psram_pkg::ST_WAIT;
                    end
                end
                octal_psram_pkg::ST_WAIT: begin
                    if (data_go) begin
                        st_r <= octal_psram_pkg::ST_DATA;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Burst pointer: loaded with the start address, stepped once per data cycle after the first.
    always_ff @(posedge link_clk or posedge ce_n) begin
        if (ce_n) begin
            addr_r <= '0;
            cnt_r <= '0;
            hyb_base_r <= '0;
            hyb_done_r <= 1'b0;
        end else if (st_r == octal_psram_pkg::ST_ADDR && cyc_r == octal_psram_pkg::CYC_A0) begin
            addr_r <= start;
            cnt_r <= '0;
            hyb_base_r <= (start & ~MEM_AW'(2**PAGE_LOG2 - 1))
                | (((start & ~(wl - MEM_AW'(1))) + wl) & MEM_AW'(2**PAGE_LOG2 - 1));
            hyb_done_r <= 1'b0;
        end else if (data_now && !first) begin
            addr_r <= nxt;
            cnt_r <= cnt_r + step;
            if (cnt_r + step >= wl) begin
                hyb_done_r <= cfg_r.burst_config_reg[octal_psram_pkg::HYBRID_BIT];
            end
        end
    end

    // Strobe preamble, read data and lane enables; writes latch the rising half.
    always_ff @(posedge link_clk or posedge ce_n) begin
        if (ce_n) begin
            strobe_mask_line_oe <= 2'b00;
            dq_oe <= 2'b00;
            rd_data_r <= 1'b0;
            out_rise_r <= 16'h0000;
            out_fall_r <= 16'h0000;
            rise_r <= 16'h0000;
            rise_m_r <= 2'b11;
            wr_act_r <= 1'b0;
            rwr_r <= 1'b0;
            push_r <= 1'b0;
            gr_r <= 1'b0;
        end else begin
            if (st_r == octal_psram_pkg::ST_ADDR && cyc_r == octal_psram_pkg::CYC_A1
                && ini_s2_r) begin
                strobe_mask_line_oe <= {x16 && is_mem_rd, is_rd};
                push_r <= ref_s2_r;
                gr_r <= (op_r == octal_psram_pkg::OP_GLOBAL_RST);
            end
            if (data_now && is_rd) begin
                rd_data_r <= 1'b1;
                dq_oe <= {x16 && is_mem_rd, 1'b1};
                if (is_mem_rd && x16) begin
                    out_rise_r <= {mem[ra + MEM_AW'(1)], mem[ra]};
                    out_fall_r <= {mem[ra + MEM_AW'(3)], mem[ra + MEM_AW'(2)]};
                end else if (is_mem_rd) begin
                    out_rise_r <= {8'h00, mem[ra]};
                    out_fall_r <= {8'h00, mem[ra + MEM_AW'(1)]};
                end else begin
                    out_rise_r <= {8'h00, reg_val(reg_addr, cfg_r)};
                    out_fall_r <= {8'h00, reg_val(reg_addr, cfg_r)};
                end
            end
            rise_r <= dq_i;
            rise_m_r <= strobe_mask_line_i;
            wr_act_r <= data_now && is_mem_wr;
            rwr_r <= data_now && first && (op_r == octal_psram_pkg::OP_REG_WR);
        end
    end

    // ************************
    // Link domain: falling edges
    // ************************
    always_ff @(negedge link_clk or posedge ce_n) begin
        if (ce_n) begin
            fall_r <= 8'h00;
        end else begin
            fall_r <= dq_i[7:0];
        end
    end

    // Configuration registers; only the lower lane carries their data.
    always_ff @(negedge link_clk or posedge cfg_rst) begin
        if (cfg_rst) begin
            cfg_r.latency_cfg_reg <= octal_psram_pkg::LATENCY_RST;
            cfg_r.write_cfg_reg <= octal_psram_pkg::WRITE_RST;
            cfg_r.burst_config_reg <= octal_psram_pkg::BURST_RST;
        end else if (gr_r && !ce_n) begin
            cfg_r.latency_cfg_reg <= octal_psram_pkg::LATENCY_RST;
            cfg_r.write_cfg_reg <= octal_psram_pkg::WRITE_RST;
            cfg_r.burst_config_reg <= octal_psram_pkg::BURST_RST;
        end else if (rwr_r && !ce_n) begin
            case (reg_addr_r)
                octal_psram_pkg::REG_LATENCY_ADDR: cfg_r.latency_cfg_reg <= {2'b00, rise_r[5:0]};
                octal_psram_pkg::REG_WRITE_ADDR: cfg_r.write_cfg_reg <= rise_r[7:0];
                octal_psram_pkg::REG_BURST_ADDR: cfg_r.burst_config_reg <= {1'b0, rise_r[6:0]};
                default: begin
                end
            endcase
        end
    end

    // Array writes happen on the falling edge, so the last cycle of a frame still lands.
    always_ff @(negedge link_clk) begin
        if (wr_act_r && !ce_n) begin
            if (!rise_m_r[0]) begin
                mem[addr_r] <= rise_r[7:0];
            end
            if (x16) begin
                if (!rise_m_r[1]) begin
                    mem[addr_r + MEM_AW'(1)] <= rise_r[15:8];
                end
                if (!strobe_mask_line_i[0]) begin
                    mem[addr_r + MEM_AW'(2)] <= dq_i[7:0];
                end
                if (!strobe_mask_line_i[1]) begin
                    mem[addr_r + MEM_AW'(3)] <= dq_i[15:8];
                end
            end else if (!strobe_mask_line_i[0]) begin
                mem[addr_r + MEM_AW'(1)] <= dq_i[7:0];
            end
        end
    end

    // DDR output: high phase shows the rising half, low phase the falling half.
    assign dq_o = link_clk ? out_rise_r : out_fall_r;
    assign strobe_mask_line_o = {2{rd_data_r & link_clk}};

endmodule

// file: octal_psram_props.sv
// Purpose: Assertions on the pins of the octal DDR memory device.
// Assumes: The host stops link_clk between frames.
// Notes: Link checks sample on the falling link edge, after the rise updates land.
`timescale 1ns/1ps
module octal_psram_props #(
    parameter int INIT_CYCLES = 20
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic hw_reset_n,
    input wire logic refresh_req,
    input wire logic init_done,
    input wire logic x16_mode,
    input wire logic link_clk,
    input wire logic ce_n,
    input wire logic [15:0] dq_i,
    input wire logic [15:0] dq_o,
    input wire logic [1:0] dq_oe,
    input wire logic [1:0] strobe_mask_line_i,
    input wire logic [1:0] strobe_mask_line_o,
    input wire logic [1:0] strobe_mask_line_oe
);
    logic [5:0] rise_r;
    logic [7:0] op_r;
    int cyc_r;
    logic is_rd;
    // Read opcodes are synchronous, linear and register reads.
    assign is_rd = op_r inside {8'h00, 8'h20, 8'h40};
    // Rises since select fell; select high clears it at once.
    always_ff @(posedge link_clk or posedge ce_n) begin
        if (ce_n) rise_r <= 6'h00;
        else if (rise_r != 6'h3F) rise_r <= rise_r + 6'h01;
    end
    // The opcode is taken at the first rise of each frame.
    always_ff @(posedge link_clk) begin
        if (rise_r == 6'h00) op_r <= dq_i[7:0];
    end
    // Core cycles since reset, saturating so it never wraps.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) cyc_r <= 0;
        else if (cyc_r < INIT_CYCLES + 8) cyc_r <= cyc_r + 1;
    end
    sequence s_rd_a1;
        rise_r == 6'h03 && is_rd;
    endsequence
    sequence s_strobe_held;
        strobe_mask_line_oe[0] [*3];
    endsequence
    AST_STROBE_FROM_A1: assert property (@(negedge link_clk)
        disable iff (rst || !init_done) s_rd_a1 |-> s_strobe_held)
        else $error("read strobe not driven from third rise");
    AST_QUIET_IN_ADDRESS: assert property (@(negedge link_clk) disable iff (rst)
        rise_r < 6'h03 |-> dq_oe == 2'b00 && strobe_mask_line_oe == 2'b00)
        else $error("bus driven during opcode or address");
    AST_NO_EARLY_DATA: assert property (@(negedge link_clk) disable iff (rst)
        rise_r < 6'h06 |-> dq_oe == 2'b00) else $error("read data before minimum latency");
    AST_WRITE_NO_DRIVE: assert property (@(negedge link_clk) disable iff (rst)
        !is_rd |-> dq_oe == 2'b00 && strobe_mask_line_oe == 2'b00)
        else $error("bus driven in a non-read frame");
    AST_IDLE_DESELECTED: assert property (@(posedge core_clk) disable iff (rst)
        ce_n && $past(ce_n) |-> dq_oe == 2'b00 && strobe_mask_line_oe == 2'b00)
        else $error("bus driven while deselected");
    AST_X8_UPPER_IDLE: assert property (@(posedge core_clk) disable iff (rst)
        !x16_mode |-> !dq_oe[1] && !strobe_mask_line_oe[1]) else $error("upper lane driven");
    AST_STROBE_WITH_DATA: assert property (@(posedge core_clk) disable iff (rst)
        dq_oe[0] |-> strobe_mask_line_oe[0]) else $error("data driven without strobe");
    AST_INIT_WAIT: assert property (@(posedge core_clk) disable iff (rst)
        cyc_r < INIT_CYCLES - 2 |-> !init_done) else $error("init finished early");
    AST_INIT_END: assert property (@(posedge core_clk) disable iff (rst)
        cyc_r > INIT_CYCLES + 2 |-> init_done) else $error("init not finished in time");
endmodule
bind octal_psram_device octal_psram_props #(.INIT_CYCLES(INIT_CYCLES)) props_i (.*);

// file: octal_psram_host.sv
// Purpose: Host controller model that drives frames on the octal DDR link.
// Assumes: Eight-bit mode; link clock period 12 ns, stopped low between frames.
// Notes: Released lines show the inverse of their last value.
`timescale 1ns/1ps
module octal_psram_host (
    output logic link_clk,
    output logic ce_n,
    output logic [15:0] dq_i,
    output logic [1:0] strobe_mask_line_i,
    input wire logic [15:0] dq_o,
    input wire logic [1:0] dq_oe,
    input wire logic [1:0] strobe_mask_line_o,
    input wire logic [1:0] strobe_mask_line_oe
);
    logic [15:0] hdq = 16'hA5A5;
    logic [1:0] hsm = 2'h1;
    // Each lane carries the device value while it drives, else the host value.
    assign dq_i[7:0] = dq_oe[0] ? dq_o[7:0] : hdq[7:0];
    assign dq_i[15:8] = dq_oe[1] ? dq_o[15:8] : hdq[15:8];
    assign strobe_mask_line_i[0] = strobe_mask_line_oe[0] ? strobe_mask_line_o[0] : hsm[0];
    assign strobe_mask_line_i[1] = strobe_mask_line_oe[1] ? strobe_mask_line_o[1] : hsm[1];
    // Deselected with the clock low from time zero.
    initial begin
        link_clk = 1'b0;
        ce_n = 1'b1;
    end
    // One frame of n cycles; write data starts at cycle ws, and ws of 0 means no data.
    task automatic frame(input logic [7:0] op, input logic [31:0] adr, input int n, input int ws,
        input logic [31:0] wd, input logic [3:0] wm, output logic [31:0] rd, output int dc);
        int k;
        int j;
        rd = 32'h0;
        dc = 0;
        ce_n = 1'b0;
        for (int i = 1; i <= n; i++) begin
            for (int h = 0; h < 2; h++) begin
                k = (i - ws) * 2 + h;
                j = (i - 2) * 2 + h;
                hsm = ~hsm;
                if (i == 1) hdq[7:0] = op;
                else if (i <= 3) hdq[7:0] = adr[8 * (3 - j) +: 8];
                else if (ws > 0 && k >= 0 && k < 4) begin
                    hdq[7:0] = wd[8 * (3 - k) +: 8];
                    hsm[0] = wm[3 - k];
                end else hdq = ~hdq;
                #3 link_clk = (h == 0);
                #3 if (h == 0 && dc == 0 && strobe_mask_line_o[0] === 1'b1) dc = i;
                k = (i - dc) * 2 + h;
                if (dc > 0 && k < 4) rd[8 * (3 - k) +: 8] = dq_o[7:0];
            end
        end
        #3 ce_n = 1'b1;
        hdq = ~hdq;
        // Extra select-high time keeps short writes apart.
        #20;
    endtask
endmodule

// file: testbench.sv
// Purpose: Self-checking bench for the octal DDR memory device.
// Assumes: Eight-bit mode; the init count is cut to 20 core cycles.
// Notes: Read data and latency are located by the strobe, as a real host does.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin errors++; \
    $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end
module testbench;
    localparam int INIT_N = 20;
    localparam logic [31:0] ADR = 32'h0000_0124;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic hw_reset_n = 1'b1;
    logic refresh_req = 1'b0;
    logic init_done, x16_mode, link_clk, ce_n;
    logic [15:0] dq_i, dq_o;
    logic [1:0] dq_oe, strobe_mask_line_i, strobe_mask_line_o, strobe_mask_line_oe;
    logic [31:0] rd;
    int dc;
    int errors = 0;
    int check_count = 0;
    int cyc = 0;
    always #4 core_clk = ~core_clk;
    octal_psram_device #(.INIT_CYCLES(INIT_N)) octal_psram_device_i (.*);
    octal_psram_host octal_psram_host_i (.*);
    // A hang ends the run as a failure.
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            complete_run();
        end
    end
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic xfer(input logic [7:0] op, input logic [31:0] adr, input int n, input int ws,
        input logic [31:0] wd, input logic [3:0] wm);
        octal_psram_host_i.frame(op, adr, n, ws, wd, wm, rd, dc);
    endtask
    // Register reads repeat the byte on both halves of the lower lane.
    task automatic reg_rd(input logic [7:0] ma, input logic [7:0] e, input int edc);
        xfer(octal_psram_pkg::OP_REG_RD, {24'h0, ma}, 12, 0, 32'h0, 4'h0);
        `CHK("reg rise byte", e, rd[31:24])
        `CHK("reg fall byte", e, rd[23:16])
        `CHK("reg read latency", edc, dc)
    endtask
    // Register writes take the rise byte of cycle 4.
    task automatic reg_wr(input logic [7:0] ma, input logic [7:0] v);
        xfer(octal_psram_pkg::OP_REG_WR, {24'h0, ma}, 4, 4, {v, 24'h0}, 4'h0);
    endtask
    task automatic mem_rd(input logic [7:0] op, input logic [31:0] e, input int edc);
        xfer(op, ADR, 16, 0, 32'h0, 4'h0);
        `CHK("mem data", e, rd)
        `CHK("mem read latency", edc, dc)
    endtask
    initial begin
        repeat (8) @(posedge core_clk);
        #1 rst = 1'b0;
        `CHK("init low", 1'b0, init_done)
        repeat (INIT_N + 4) @(posedge core_clk);
        #1 `CHK("init high", 1'b1, init_done)
        $display("test init done");
        reg_rd(8'h00, 8'h08, 8);
        reg_rd(8'h08, 8'h05, 8);
        reg_rd(8'h03, 8'h80, 8);
        reg_wr(8'h01, 8'hFF);
        reg_rd(8'h01, 8'h00, 8);
        $display("test register defaults done");
        reg_wr(8'h00, 8'h00);
        reg_rd(8'h00, 8'h00, 6);
        xfer(octal_psram_pkg::OP_SYNC_WR, ADR, 9, 8, 32'h11223344, 4'h0);
        xfer(octal_psram_pkg::OP_SYNC_WR, ADR, 9, 8, 32'h55667788, 4'h6);
        mem_rd(octal_psram_pkg::OP_LIN_RD, 32'h55223388, 6);
        $display("test write mask done");
        @(posedge core_clk) #1 refresh_req = 1'b1;
        repeat (4) @(posedge core_clk);
        mem_rd(octal_psram_pkg::OP_SYNC_RD, 32'h55223388, 9);
        @(posedge core_clk) #1 refresh_req = 1'b0;
        reg_wr(8'h00, 8'h20);
        mem_rd(octal_psram_pkg::OP_SYNC_RD, 32'h55223388, 9);
        xfer(8'h11, ADR, 16, 0, 32'h0, 4'h0);
        `CHK("unknown opcode strobe", 0, dc)
        $display("test latency done");
        @(posedge core_clk) #1 hw_reset_n = 1'b0;
        repeat (5) @(posedge core_clk);
        #1 hw_reset_n = 1'b1;
        repeat (5) @(posedge core_clk);
        reg_rd(8'h00, 8'h08, 8);
        reg_wr(8'h00, 8'h00);
        reg_wr(8'h08, 8'h45);
        `CHK("x16 mode on", 1'b1, x16_mode)
        xfer(octal_psram_pkg::OP_GLOBAL_RST, 32'h0, 4, 0, 32'h0, 4'h0);
        reg_rd(8'h00, 8'h08, 8);
        `CHK("x16 mode off", 1'b0, x16_mode)
        $display("test resets done");
        complete_run();
    end
endmodule
